//--- hdl/spi_link_pkg.sv
package spi_link_pkg;
  localparam int frame_bits = 16;
  localparam int addr_bits = 7;
  localparam int data_bits = 8;
  localparam int cnt_bits = 8;
  localparam int wr_bit_pos = 15;
  localparam int addr_msb_pos = 14;
  localparam int addr_lsb_pos = 8;
  localparam int data_msb_pos = 7;
  localparam logic [6:0] diag_addr = 7'h00;
  localparam logic [7:0] diag_reset_val = 8'h04;
  localparam int supply_low_pos = 2;
  localparam int fifo_depth = 32;
  localparam int clk_mhz = 50;
  localparam int xfer_delay_ns = 400;
  localparam int xfer_delay_cyc = (xfer_delay_ns * clk_mhz + 999) / 1000;
  // eight cycles: the echoed miso bit must cross both synchronisers
  // before the master samples it, and the high time stays above 90 ns
  localparam int sclk_half_cyc = 8;
  typedef logic [15:0] frame_t;
endpackage : spi_link_pkg

//--- hdl/spi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic chain_select_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  modport device (input chain_select_n, input sclk, input mosi,
                  output miso_o, output miso_oe_n);
  modport host (output chain_select_n, output sclk, output mosi,
                input miso_o, input miso_oe_n);
endinterface : spi_link_if
`default_nettype wire

//--- hdl/frame_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module frame_fifo #(
  parameter int width = 16,
  parameter int depth = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw:0] wr_q;
  logic [aw:0] rd_q;
  assign in_ready = (wr_q - rd_q) != (aw+1)'(depth);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[aw-1:0]];
  always_ff @(posedge ref_clk)
  begin
    if (in_valid && in_ready)
    begin
      mem[wr_q[aw-1:0]] <= in_data;
    end
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : frame_fifo
`default_nettype wire

//--- hdl/spi_slave_end.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - sixteen-bit frames, msb first both ways
// - frame spans select fall to select rise
// - sample mosi on fall, launch miso rise
// - modulo-16 clock count validates frame
// - wrong count flags error, discards frame
// - select high: ignore inputs, miso released
// - select fall loads response, miso low
// - rising clock presents shifted-out msb
// - falling clock shifts, inserts mosi, counts
// - master holds select low whole frame
// - valid nonzero multiple executes command
// - master waits 400 ns between frames
// - acts as sixteen-bit chain shift stage
// - master clocks sixteen per chained device
// - answer only in the next transfer
// - write bit, seven address, eight data
// - read answer returns address and contents
// - write answer returns diagnosis register
// - response msb is transmission error flag
// - after error answer diagnosis, flag set
// - first answer after reset flags error
// - first answer diagnosis with supply flag
module spi_slave_end
  import spi_link_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  spi_link_if.device link,
  output logic [spi_link_pkg::addr_bits-1:0] reg_addr,
  input wire logic [spi_link_pkg::data_bits-1:0] reg_rdata,
  input wire logic [spi_link_pkg::data_bits-1:0] diag_rdata,
  output logic reg_we,
  output logic [spi_link_pkg::data_bits-1:0] reg_wdata,
  output logic xfer_error_flag
);
  import spi_link_pkg::*;
  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [1:0] cs_s_q;
  logic [1:0] sck_s_q;
  logic [1:0] mosi_s_q;
  logic cs_q;
  logic sck_q;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_s_q <= 2'h3;
      sck_s_q <= 2'h0;
      mosi_s_q <= 2'h0;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
    end
    else
    begin
      cs_s_q <= {cs_s_q[0], link.chain_select_n};
      sck_s_q <= {sck_s_q[0], link.sclk};
      mosi_s_q <= {mosi_s_q[0], link.mosi};
      cs_q <= cs_s_q[1];
      sck_q <= sck_s_q[1];
    end
  end
  logic active;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign active = !cs_s_q[1];
  assign cs_fall = cs_q && !cs_s_q[1];
  assign cs_rise = !cs_q && cs_s_q[1];
  assign sck_rise = active && !cs_q && !sck_q && sck_s_q[1];
  assign sck_fall = active && !cs_q && sck_q && !sck_s_q[1];
  // ***************************************************
  // shift stage
  // ***************************************************
  frame_t shift_q;
  frame_t resp_q;
  logic [cnt_bits-1:0] cnt_q;
  logic miso_q;
  logic oe_n_q;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      shift_q <= '0;
      cnt_q <= '0;
      miso_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (cs_fall)
    begin
      shift_q <= resp_q;
      cnt_q <= '0;
      miso_q <= 1'b0;
      oe_n_q <= 1'b0;
    end
    else if (!active)
    begin
      oe_n_q <= 1'b1;
    end
    else if (sck_rise)
    begin
      miso_q <= shift_q[frame_bits-1];
    end
    else if (sck_fall)
    begin
      shift_q <= {shift_q[frame_bits-2:0], mosi_s_q[1]};
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign link.miso_o = miso_q;
  assign link.miso_oe_n = oe_n_q;
  // ***************************************************
  // command execution at select rise
  // ***************************************************
  logic frame_ok;
  logic is_write;
  logic [addr_bits-1:0] cmd_addr;
  // wrapping 8-bit count limits chains to fifteen devices
  assign frame_ok = (cnt_q[3:0] == 4'h0) && (cnt_q != '0);
  assign is_write = shift_q[wr_bit_pos];
  assign cmd_addr = shift_q[addr_msb_pos:addr_lsb_pos];
  logic first_q;
  logic err_q;
  logic rd_pend_q;
  logic [addr_bits-1:0] rd_addr_q;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      first_q <= 1'b1;
      err_q <= 1'b1;
      rd_pend_q <= 1'b0;
      rd_addr_q <= diag_addr;
      reg_we <= 1'b0;
      reg_wdata <= '0;
    end
    else
    begin
      reg_we <= 1'b0;
      if (cs_rise)
      begin
        first_q <= 1'b0;
        err_q <= !frame_ok;
        if (frame_ok)
        begin
          rd_pend_q <= !is_write;
          rd_addr_q <= is_write ? diag_addr : cmd_addr;
          reg_we <= is_write;
          reg_wdata <= shift_q[data_msb_pos:0];
        end
        else
        begin
          rd_pend_q <= 1'b0;
          rd_addr_q <= diag_addr;
        end
      end
    end
  end
  // ***************************************************
  // register write port
  // ***************************************************
  // the strobe comes one cycle after select rise, so the target
  // address is held here rather than taken from the read path
  logic [addr_bits-1:0] wr_addr_q;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_addr_q <= diag_addr;
    end
    else if (cs_rise && frame_ok)
    begin
      wr_addr_q <= cmd_addr;
    end
  end
  assign reg_addr = cs_rise ? cmd_addr : (reg_we ? wr_addr_q : rd_addr_q);
  assign xfer_error_flag = err_q;
  // response is composed between frames, delivered next frame
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      resp_q <= {1'b1, diag_addr, diag_reset_val};
    end
    else if (!active && !cs_rise)
    begin
      if (first_q)
      begin
        resp_q <= {1'b1, diag_addr, diag_rdata | diag_reset_val};
      end
      else if (rd_pend_q)
      begin
        resp_q <= {err_q, rd_addr_q, reg_rdata};
      end
      else
      begin
        resp_q <= {err_q, diag_addr, diag_rdata};
      end
    end
  end
endmodule : spi_slave_end
`default_nettype wire

//--- hdl/spi_master_end.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_end
  import spi_link_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  spi_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [spi_link_pkg::frame_bits-1:0] cmd_data,
  input wire logic [3:0] chain_len,
  output logic resp_valid,
  input wire logic resp_ready,
  output logic [spi_link_pkg::frame_bits-1:0] resp_data
);
  import spi_link_pkg::*;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_shift = 4'b0010,
    st_end = 4'b0100,
    st_gap = 4'b1000
  } mst_state_t;
  mst_state_t state_q;
  logic [1:0] miso_s_q;
  logic [7:0] div_q;
  logic [7:0] bit_q;
  logic [7:0] total;
  logic sck_q;
  logic cs_n_q;
  logic mosi_q;
  frame_t tx_q;
  frame_t rx_q;
  logic push;
  logic tick;
  logic fifo_room;
  assign total = {chain_len, 4'h0};
  assign tick = div_q == 8'(sclk_half_cyc - 1);
  assign cmd_ready = (state_q == st_idle) && cmd_valid;
  frame_fifo #(.width(frame_bits), .depth(fifo_depth)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_room),
    .in_data(rx_q),
    .out_valid(resp_valid),
    .out_ready(resp_ready),
    .out_data(resp_data)
  );
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      miso_s_q <= 2'h0;
    end
    else
    begin
      miso_s_q <= {miso_s_q[0], link.miso_o};
    end
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= st_idle;
      div_q <= '0;
      bit_q <= '0;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      tx_q <= '0;
      rx_q <= '0;
      push <= 1'b0;
    end
    else
    begin
      push <= 1'b0;
      div_q <= tick ? 8'h00 : div_q + 1'b1;
      case (state_q)
        st_idle:
        begin
          if (cmd_valid && chain_len != 4'h0 && fifo_room)
          begin
            tx_q <= cmd_data;
            cs_n_q <= 1'b0;
            bit_q <= '0;
            state_q <= st_shift;
          end
        end
        st_shift:
        begin
          if (tick)
          begin
            sck_q <= !sck_q;
            if (!sck_q)
            begin
              mosi_q <= tx_q[frame_bits-1];
              tx_q <= {tx_q[frame_bits-2:0], 1'b0};
            end
            else
            begin
              rx_q <= {rx_q[frame_bits-2:0], miso_s_q[1]};
              bit_q <= bit_q + 1'b1;
              if (bit_q[3:0] == 4'hf)
              begin
                push <= 1'b1;
              end
              if (bit_q + 1'b1 == total)
              begin
                state_q <= st_end;
              end
            end
          end
        end
        st_end:
        begin
          if (tick)
          begin
            cs_n_q <= 1'b1;
            bit_q <= '0;
            state_q <= st_gap;
          end
        end
        st_gap:
        begin
          bit_q <= bit_q + 1'b1;
          if (bit_q == 8'(xfer_delay_cyc))
          begin
            state_q <= st_idle;
          end
        end
        default:
        begin
          state_q <= st_idle;
        end
      endcase
    end
  end
  assign link.chain_select_n = cs_n_q;
  assign link.sclk = sck_q;
  assign link.mosi = mosi_q;
endmodule : spi_master_end
`default_nettype wire

//--- tb/spi_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module spi_link_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chain_select_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  // ****
  // serial clocks per frame
  // ****
  logic sclk_q;
  logic [7:0] cnt_q;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk;
  // cleared while idle so the count seen at select rise is the whole frame
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      cnt_q <= 8'h00;
    else if (chain_select_n)
      cnt_q <= 8'h00;
    else if (sclk && !sclk_q)
      cnt_q <= cnt_q + 8'h01;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_oe_off;
    chain_select_n [*8] |-> miso_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("miso driven while idle");
  property p_oe_on;
    $fell(chain_select_n) |-> ##[1:8] !miso_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("miso not enabled");
  property p_rel;
    $rose(chain_select_n) |-> ##[1:8] miso_oe_n;
  endproperty
  a_rel: assert property (p_rel)
    else $error("miso not released");
  property p_low;
    $fell(miso_oe_n) |-> !miso_o;
  endproperty
  a_low: assert property (p_low)
    else $error("miso not low at start");
  property p_idle;
    chain_select_n && $past(chain_select_n) |-> !sclk;
  endproperty
  a_idle: assert property (p_idle)
    else $error("clock outside frame");
  property p_gap;
    $rose(chain_select_n) |-> chain_select_n [*8] ##1
      chain_select_n [*8] ##1 chain_select_n [*4];
  endproperty
  a_gap: assert property (p_gap)
    else $error("select gap short");
  property p_half;
    $rose(sclk) |-> sclk [*8] ##1 !sclk;
  endproperty
  a_half: assert property (p_half)
    else $error("clock high time wrong");
  property p_count;
    $rose(chain_select_n) |-> cnt_q[3:0] == 4'h0 && cnt_q != 8'h00;
  endproperty
  a_count: assert property (p_count)
    else $error("frame clock count wrong");
  property p_mosi;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  a_mosi: assert property (p_mosi)
    else $error("mosi moved while clock high");
  c_frame: cover property ($rose(chain_select_n));
  c_one: cover property (!miso_oe_n && miso_o);
  c_chain: cover property ($rose(chain_select_n) && cnt_q == 8'h20);
endmodule : spi_link_asserts
`default_nettype wire

//--- tb/test_spi_cmd_response_slave.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_cmd_response_slave;
  import spi_link_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  frame_t cmd_data = 16'h0000;
  logic [3:0] chain_len = 4'h1;
  logic resp_valid;
  logic resp_ready = 1'b0;
  frame_t resp_data;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] mem [128];
  logic reg_we, reg_we2, err_flag, err_flag2;
  int n_mismatch = 0;
  int compares = 0;
  int we2_seen = 0;
  spi_link_if lk ();
  spi_link_if lk2 ();
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (reg_we)
      mem[reg_addr] <= reg_wdata;
  always @(posedge ref_clk)
    if (reg_we2)
      we2_seen++;
  spi_master_end u_spi_master_end (.ref_clk(ref_clk), .rst(rst),
    .link(lk.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_data(cmd_data), .chain_len(chain_len), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp_data(resp_data));
  spi_slave_end u_spi_slave_end (.ref_clk(ref_clk), .rst(rst),
    .link(lk.device), .reg_addr(reg_addr), .reg_rdata(mem[reg_addr]),
    .diag_rdata(mem[0]), .reg_we(reg_we), .reg_wdata(reg_wdata),
    .xfer_error_flag(err_flag));
  // second end faces a hand-driven master that can miscount clocks
  spi_slave_end u_spi_slave_end_2 (.ref_clk(ref_clk), .rst(rst),
    .link(lk2.device), .reg_addr(), .reg_rdata(8'h00),
    .diag_rdata(8'h00), .reg_we(reg_we2), .reg_wdata(),
    .xfer_error_flag(err_flag2));
  spi_link_asserts u_spi_link_asserts (.ref_clk(ref_clk), .rst(rst),
    .chain_select_n(lk.chain_select_n), .sclk(lk.sclk), .mosi(lk.mosi),
    .miso_o(lk.miso_o), .miso_oe_n(lk.miso_oe_n));
  // ****
  // shared tasks
  // ****
  task automatic chk(input string what, input frame_t exp, input frame_t got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic getr(input frame_t exp);
    int i;
    i = 0;
    while (resp_valid !== 1'b1 && i < 5000)
    begin
      @(negedge ref_clk);
      i++;
    end
    chk("resp_valid", 16'h0001, {15'h0000, resp_valid});
    chk("resp_data", exp, resp_data);
    resp_ready = 1'b1;
    @(negedge ref_clk);
    resp_ready = 1'b0;
  endtask : getr
  task automatic xfer(input frame_t cmd, input frame_t exp);
    int i;
    i = 0;
    cmd_data = cmd;
    cmd_valid = 1'b1;
    // let cmd_ready settle, else an idle master is seen busy and
    // the same command is taken a second time
    #1;
    while (cmd_ready !== 1'b1 && i < 5000)
    begin
      @(negedge ref_clk);
      i++;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    getr(exp);
  endtask : xfer
  // 160 ns link clock; mosi moves mid-low, clear of both edges
  task automatic bb(input frame_t w, input int n, output frame_t r);
    r = 16'h0000;
    lk2.chain_select_n = 1'b0;
    #200;
    for (int k = 0; k < n; k++)
    begin
      lk2.mosi = w[15-k];
      #40 lk2.sclk = 1'b1;
      #80 lk2.sclk = 1'b0;
      r = {r[14:0], lk2.miso_o};
      #40;
    end
    #200 lk2.chain_select_n = 1'b1;
    lk2.mosi = ~lk2.mosi;
    #600;
  endtask : bb
  // ****
  // scenarios
  // ****
  task automatic t_rw;
    xfer(16'h0500, {1'b1, diag_addr, 8'h5a | diag_reset_val});
    xfer(16'h83a5, {1'b0, 7'h05, 8'h5f});
    xfer(16'h0300, {1'b0, diag_addr, 8'h5a});
    xfer(16'h0400, {1'b0, 7'h03, 8'ha5});
    chk("flag", 16'h0000, {15'h0000, err_flag});
    $display("test rw done");
  endtask : t_rw
  task automatic t_chain;
    chain_len = 4'h2;
    xfer(16'h8655, {1'b0, 7'h04, 8'h5e});
    getr(16'h8655);
    chain_len = 4'h1;
    xfer(16'h0600, {1'b0, diag_addr, 8'h5a});
    xfer(16'h0000, {1'b0, 7'h06, 8'h5c});
    $display("test chain done");
  endtask : t_chain
  task automatic t_err;
    frame_t r;
    bb(16'h0100, 16, r);
    chk("first", {1'b1, diag_addr, diag_reset_val}, r);
    chk("oe_n", 16'h0001, {15'h0000, lk2.miso_oe_n});
    chk("flag ok", 16'h0000, {15'h0000, err_flag2});
    bb(16'h81c3, 15, r);
    chk("short", 16'h0080, r);
    chk("flag err", 16'h0001, {15'h0000, err_flag2});
    chk("we", 16'h0000, we2_seen[15:0]);
    bb(16'h0000, 16, r);
    chk("after err", {1'b1, diag_addr, 8'h00}, r);
    $display("test err done");
  endtask : t_err
  task automatic give_verdict;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    lk2.chain_select_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.mosi = 1'b0;
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_rw();
    t_chain();
    t_err();
    give_verdict();
  end
  initial
  begin
    #300000;
    n_mismatch++;
    give_verdict();
  end
endmodule : test_spi_cmd_response_slave
`default_nettype wire
